// ### shared/pts_pkg.sv
package pts_pkg;
	// Timing
	localparam int CLK_HZ          = 10_000_000;
	localparam int TICK_MS         = 5;
	localparam int TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
	localparam int DELTA_MS        = 20;
	localparam int HIST_DEPTH      = DELTA_MS / TICK_MS;

	// Structure
	localparam int NCH  = 3;
	localparam int FXW  = 40;
	localparam int DIVW = 48;

	// Arithmetic constants, values carried in units of 0.0001 except hysteresis (millionths), ratios (percent) and delays (ticks)
	localparam logic signed [79:0] SCALED_LIM = 80'shBA43B7400;
	localparam logic signed [79:0] RATIO_LIM  = 80'sh1DCD6500;
	localparam logic signed [79:0] FX_ONE     = 80'sh2710;
	localparam logic signed [79:0] HYST_FULL  = 80'shF4240;
	localparam logic signed [79:0] PCT_MUL    = 80'shF4240;
	localparam logic signed [79:0] RATIO_MUL  = 80'sh64;
	localparam logic [31:0]        HYST_MAX   = 32'h0007A120;
	localparam logic [31:0]        DLY_MAX    = 32'h00057E40;

	// Reset values
	localparam logic [31:0] CTRL_RST    = 32'h00000002;
	localparam logic [31:0] SCALE_RST   = 32'h00002710;
	localparam logic [31:0] PICKUP_RST  = 32'h00000064;
	localparam logic [31:0] HYST_RST    = 32'h00007530;
	localparam logic [31:0] BLKLIM_RST  = 32'h00000000;
	localparam logic [31:0] OP_DLY_RST  = 32'h00000008;
	localparam logic [31:0] REL_DLY_RST = 32'h0000000C;

	// Register byte offsets
	localparam logic [7:0] OFF_CTRL       = 8'h00;
	localparam logic [7:0] OFF_MODE       = 8'h04;
	localparam logic [7:0] OFF_SCALE      = 8'h08;
	localparam logic [7:0] OFF_PICKUP     = 8'h14;
	localparam logic [7:0] OFF_HYST       = 8'h20;
	localparam logic [7:0] OFF_BLKLIM     = 8'h2C;
	localparam logic [7:0] OFF_CALC_PK    = 8'h38;
	localparam logic [7:0] OFF_OP_DLY     = 8'h3C;
	localparam logic [7:0] OFF_REL_DLY    = 8'h40;
	localparam logic [7:0] OFF_COND       = 8'h44;
	localparam logic [7:0] OFF_EXP_T      = 8'h48;
	localparam logic [7:0] OFF_REM_T      = 8'h4C;
	localparam logic [7:0] OFF_SCALED     = 8'h50;
	localparam logic [7:0] OFF_RATIO      = 8'h5C;
	localparam logic [7:0] OFF_CALC_RATIO = 8'h68;
	localparam logic [7:0] OFF_EVT        = 8'h6C;
	localparam logic [7:0] OFF_MASK       = 8'h70;

	// Field positions
	localparam int CTRL_EN_BIT  = 0;
	localparam int CTRL_CNT_LSB = 1;
	localparam int MODE_STRIDE  = 4;
	localparam int EVT_START    = 0;
	localparam int EVT_TRIP     = 1;
	localparam int EVT_BLOCK    = 2;
	localparam int EVT_RELEASE  = 3;
	localparam int EVT_W        = 4;

	typedef enum logic [2:0] {
		MODE_OVER, MODE_OVER_ABS, MODE_UNDER, MODE_UNDER_ABS,
		MODE_DSET_PCT, MODE_DABS_PCT, MODE_DSET_VAL, MODE_DABS_VAL
	} pts_mode_e;

	typedef enum logic [1:0] {COND_NORMAL, COND_START, COND_TRIP, COND_BLOCKED} pts_cond_e;

	typedef struct packed {
		pts_mode_e          mode;
		logic signed [31:0] scale;
		logic signed [31:0] pickup;
		logic [31:0]        hyst;
		logic signed [31:0] blklim;
	} pts_chcfg_s;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} pts_wb_req_s;

	typedef struct packed {
		logic start;
		logic trip;
		logic blocked;
	} pts_flags_s;

	typedef logic [NCH-1:0][31:0] pts_meas_t;
endpackage

// ### hdl/pts_div.sv
`timescale 1ns/10ps
module pts_div #(
	parameter int W  = 48,
	parameter int DW = 32
) (
	input  wire logic                 clk,   // System clock
	input  wire logic                 rst,   // Async reset, high
	input  wire logic                 start, // Begin a division
	input  wire logic signed [W-1:0]  num,   // Dividend
	input  wire logic signed [DW-1:0] den,   // Divisor
	output logic                      done,  // Quotient valid pulse
	output logic signed [W-1:0]       quo    // Signed quotient
);
	typedef struct packed {
		logic         busy;
		logic         done;
		logic         neg;
		logic [6:0]   cnt;
		logic [W-1:0] rem;
		logic [W-1:0] q;
		logic [W-1:0] dm;
		logic [W-1:0] quo;
	} pts_div_st_s;

	pts_div_st_s s_r, s_n;
	logic [W-1:0] trial;

	if (W > 64 || DW >= W) begin : g_chk
		$error("pts_div: unsupported widths");
	end

	assign trial = {s_r.rem[W-2:0], s_r.q[W-1]};

	always_comb begin
		s_n = s_r;
		s_n.done = 1'b0;
		if (start) begin
			s_n.neg = num[W-1] ^ den[DW-1];
			s_n.q = num[W-1] ? W'(-num) : W'(num);
			s_n.dm = den[DW-1] ? W'(-W'(den)) : W'(den);
			s_n.rem = '0;
			s_n.cnt = 7'(W);
			s_n.busy = (den != '0);
			if (den == '0) begin
				// Zero divisor saturates toward the dividend's sign
				s_n.done = 1'b1;
				s_n.quo = num[W-1] ? {1'b1, {(W-2){1'b0}}, 1'b1} : {1'b0, {(W-1){1'b1}}};
			end
		end else if (s_r.busy) begin
			s_n.q = {s_r.q[W-2:0], 1'b0};
			s_n.rem = trial;
			if (trial >= s_r.dm) begin
				s_n.rem = trial - s_r.dm;
				s_n.q[0] = 1'b1;
			end
			s_n.cnt = s_r.cnt - 7'h01;
			if (s_r.cnt == 7'h01) begin
				s_n.busy = 1'b0;
				s_n.done = 1'b1;
				s_n.quo = s_r.neg ? W'(-s_n.q) : s_n.q;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_n;
		end
	end

	assign done = s_r.done;
	assign quo = $signed(s_r.quo);
endmodule

// ### hdl/pts_stage.sv
// Functional notes
// - Follow one to three signals; all followed signals must pick up together
// - Scaled value is measurement times factor, clamped
// - Factor 1.0 passes measurement unchanged
// - Condition reads normal, start, trip or blocked
// - Expected operating time shown, signed milliseconds
// - Remaining time to trip counts down
// - Per-signal measured to pick-up ratio each cycle
// - Combined signed-sum ratio, clamped to five million
// - Eight comparator modes, over after reset
// - Signed pick-up in 0.0001 steps, default 0.01
// - Hysteresis relative to pick-up, default 3 percent
// - Operate delay then trip; release delay after drop
// - Delta modes compare change over 20 ms
// - Under modes suppressed below blocking limit
// - Block at pick-up gives blocked, resets start
`timescale 1ns/10ps
module pts_stage #(
	parameter int TICK_CYCLES = pts_pkg::TICK_CYCLES_DEF
) (
	input  wire logic                 ref_clk,  // System clock
	input  wire logic                 rst,      // Async reset, high
	input  wire pts_pkg::pts_wb_req_s wb_req,   // Wishbone request
	output logic                      wb_ack,   // Wishbone acknowledge
	output logic [31:0]               wb_dat_r, // Wishbone read data
	output logic                      irq,      // Interrupt level
	input  wire pts_pkg::pts_meas_t   meas,     // Raw measurements
	input  wire logic                 block_in, // Blocking input
	output pts_pkg::pts_flags_s       flags     // Stage outputs
);
	import pts_pkg::*;

	typedef struct packed {
		logic                                 ack;
		logic [31:0]                          rdat;
		logic                                 irq;
		pts_flags_s                           flags;
		logic                                 en;
		logic [1:0]                           cnt;
		pts_chcfg_s [NCH-1:0]                 cfg;
		logic signed [31:0]                   calc_pk;
		logic [31:0]                          op_dly;
		logic [31:0]                          rel_dly;
		logic [EVT_W-1:0]                     mask;
		logic [EVT_W-1:0]                     evt;
		logic [31:0]                          tick_cnt;
		logic                                 eval;
		logic [NCH-1:0][FXW-1:0]              scaled;
		logic [NCH-1:0][HIST_DEPTH-1:0][FXW-1:0] hist;
		logic [NCH-1:0]                       ful;
		pts_cond_e                            cond;
		logic [31:0]                          op_cnt;
		logic [31:0]                          rel_cnt;
		logic                                 releasing;
		logic [NCH:0][31:0]                   ratio;
		logic [1:0]                           rsel;
		logic                                 rgo;
	} pts_stage_st_s;

	pts_stage_st_s s_r, s_n;

	logic signed [FXW-1:0]  scl_nxt [NCH];
	logic                   ful_eval [NCH];
	logic [NCH-1:0]         ch_en;
	logic                   pu;
	logic signed [79:0]     calc_sum;
	logic signed [DIVW-1:0] div_num;
	logic signed [31:0]     div_den;
	logic                   div_done;
	logic signed [DIVW-1:0] div_quo;

	if (TICK_CYCLES < (NCH + 1) * (DIVW + 4) || NCH > 3) begin : g_chk
		$error("pts_stage: program cycle too short for the ratio divisions");
	end

	function automatic logic signed [79:0] sat(input logic signed [79:0] v,
		input logic signed [79:0] lim);
		if (v > lim) begin
			return lim;
		end else if (v < -lim) begin
			return -lim;
		end
		return v;
	endfunction

	function automatic logic signed [79:0] absv(input logic signed [79:0] v);
		return (v < 0) ? -v : v;
	endfunction

	function automatic logic [31:0] wr_bytes(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction

	for (genvar i = 0; i < NCH; i++) begin : g_ch
		logic signed [79:0] prod, x, o, pk, hamt, d, xa, bl;
		logic set_c, hold_c, blk_c;
		assign prod = 80'($signed(meas[i])) * 80'(s_r.cfg[i].scale);
		// Factor is in 0.0001 units, so 1.0 leaves the value in 0.0001 units of the measurement
		assign scl_nxt[i] = 40'(sat(prod, SCALED_LIM));
		assign x = 80'($signed(s_r.scaled[i]));
		assign o = 80'($signed(s_r.hist[i][HIST_DEPTH-1]));
		assign pk = 80'(s_r.cfg[i].pickup);
		assign bl = 80'(s_r.cfg[i].blklim) * FX_ONE;
		assign hamt = (absv(pk) * 80'(s_r.cfg[i].hyst)) / HYST_FULL;
		assign d = x - o;
		assign xa = absv(x);
		always_comb begin
			set_c = 1'b0;
			hold_c = 1'b0;
			blk_c = 1'b0;
			case (s_r.cfg[i].mode)
				MODE_OVER: begin
					set_c = x > pk;
					hold_c = x > pk - hamt;
				end
				MODE_OVER_ABS: begin
					set_c = xa > pk;
					hold_c = xa > pk - hamt;
				end
				MODE_UNDER: begin
					set_c = x < pk;
					hold_c = x < pk + hamt;
					blk_c = x < bl;
				end
				MODE_UNDER_ABS: begin
					set_c = xa < pk;
					hold_c = xa < pk + hamt;
					blk_c = x < bl;
				end
				MODE_DSET_PCT: begin
					set_c = (pk >= 0) ? (d * PCT_MUL > pk * absv(o)) : (d * PCT_MUL < pk * absv(o));
					hold_c = set_c;
				end
				MODE_DABS_PCT: begin
					set_c = absv(d) * PCT_MUL > absv(pk) * absv(o);
					hold_c = set_c;
				end
				MODE_DSET_VAL: begin
					set_c = (pk >= 0) ? (d > pk) : (d < pk);
					hold_c = set_c;
				end
				MODE_DABS_VAL: begin
					set_c = absv(d) > absv(pk);
					hold_c = set_c;
				end
				default: begin
					set_c = 1'b0;
				end
			endcase
		end
		assign ful_eval[i] = !blk_c && (s_r.ful[i] ? hold_c : set_c);
		assign ch_en[i] = s_r.en && (2'(i) < s_r.cnt);
	end

	// All followed comparisons must hold together
	always_comb begin
		pu = |ch_en;
		calc_sum = '0;
		for (int k = 0; k < NCH; k++) begin
			if (ch_en[k]) begin
				pu = pu && ful_eval[k];
				calc_sum = calc_sum + 80'($signed(s_r.scaled[k]));
			end
		end
		calc_sum = sat(calc_sum, SCALED_LIM);
		div_num = 48'(calc_sum * RATIO_MUL);
		div_den = s_r.calc_pk;
		for (int k = 0; k < NCH; k++) begin
			if (s_r.rsel == 2'(k)) begin
				div_num = 48'(80'($signed(s_r.scaled[k])) * RATIO_MUL);
				div_den = s_r.cfg[k].pickup;
			end
		end
	end

	pts_div #(
		.W  (DIVW),
		.DW (32)
	) u_div (
		.clk   (ref_clk),
		.rst   (rst),
		.start (s_r.rgo),
		.num   (div_num),
		.den   (div_den),
		.done  (div_done),
		.quo   (div_quo)
	);

	always_comb begin
		s_n = s_r;
		s_n.ack = 1'b0;
		s_n.rgo = 1'b0;
		s_n.eval = 1'b0;

		// Program cycle: sample inputs, then evaluate one clock later
		s_n.tick_cnt = s_r.tick_cnt + 32'h1;
		if (s_r.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
			s_n.tick_cnt = '0;
			s_n.eval = 1'b1;
			for (int k = 0; k < NCH; k++) begin
				s_n.hist[k] = {s_r.hist[k][HIST_DEPTH-2:0], s_r.scaled[k]};
				s_n.scaled[k] = scl_nxt[k];
			end
		end

		if (wb_req.cyc && wb_req.stb && !s_r.ack) begin
			s_n.ack = 1'b1;
			s_n.rdat = '0;
			if (wb_req.we) begin
				case (wb_req.adr)
					OFF_CTRL: begin
						s_n.rdat = wr_bytes({29'h0, s_r.cnt, s_r.en}, wb_req.dat, wb_req.sel);
						s_n.en = s_n.rdat[CTRL_EN_BIT];
						s_n.cnt = s_n.rdat[CTRL_CNT_LSB +: 2];
					end
					OFF_MODE: begin
						for (int k = 0; k < NCH; k++) begin
							s_n.rdat[MODE_STRIDE*k +: 3] = s_r.cfg[k].mode;
						end
						s_n.rdat = wr_bytes(s_n.rdat, wb_req.dat, wb_req.sel);
						for (int k = 0; k < NCH; k++) begin
							s_n.cfg[k].mode = pts_mode_e'(s_n.rdat[MODE_STRIDE*k +: 3]);
						end
					end
					OFF_CALC_PK: s_n.calc_pk = wr_bytes(s_r.calc_pk, wb_req.dat, wb_req.sel);
					OFF_OP_DLY: begin
						s_n.op_dly = wr_bytes(s_r.op_dly, wb_req.dat, wb_req.sel);
						if (s_n.op_dly > DLY_MAX) begin
							s_n.op_dly = DLY_MAX;
						end
					end
					OFF_REL_DLY: begin
						s_n.rel_dly = wr_bytes(s_r.rel_dly, wb_req.dat, wb_req.sel);
						if (s_n.rel_dly > DLY_MAX) begin
							s_n.rel_dly = DLY_MAX;
						end
					end
					OFF_MASK: s_n.mask = EVT_W'(wr_bytes(32'(s_r.mask), wb_req.dat, wb_req.sel));
					default: begin
						for (int k = 0; k < NCH; k++) begin
							if (wb_req.adr == 8'(OFF_SCALE + 8'(4 * k))) begin
								s_n.cfg[k].scale = wr_bytes(s_r.cfg[k].scale, wb_req.dat, wb_req.sel);
							end
							if (wb_req.adr == 8'(OFF_PICKUP + 8'(4 * k))) begin
								s_n.cfg[k].pickup = wr_bytes(s_r.cfg[k].pickup, wb_req.dat, wb_req.sel);
							end
							if (wb_req.adr == 8'(OFF_HYST + 8'(4 * k))) begin
								s_n.cfg[k].hyst = wr_bytes(s_r.cfg[k].hyst, wb_req.dat, wb_req.sel);
								if (s_n.cfg[k].hyst > HYST_MAX) begin
									s_n.cfg[k].hyst = HYST_MAX;
								end
							end
							if (wb_req.adr == 8'(OFF_BLKLIM + 8'(4 * k))) begin
								s_n.cfg[k].blklim = wr_bytes(s_r.cfg[k].blklim, wb_req.dat, wb_req.sel);
							end
						end
					end
				endcase
				s_n.rdat = '0;
			end else begin
				case (wb_req.adr)
					OFF_CTRL: s_n.rdat = {29'h0, s_r.cnt, s_r.en};
					OFF_MODE: begin
						for (int k = 0; k < NCH; k++) begin
							s_n.rdat[MODE_STRIDE*k +: 3] = s_r.cfg[k].mode;
						end
					end
					OFF_CALC_PK: s_n.rdat = s_r.calc_pk;
					OFF_OP_DLY: s_n.rdat = s_r.op_dly;
					OFF_REL_DLY: s_n.rdat = s_r.rel_dly;
					OFF_COND: s_n.rdat = {30'h0, s_r.cond};
					OFF_EXP_T: s_n.rdat = 32'(s_r.op_dly * TICK_MS);
					OFF_REM_T: begin
						if (s_r.cond == COND_START) begin
							s_n.rdat = 32'((s_r.op_dly - s_r.op_cnt) * TICK_MS);
						end
					end
					OFF_CALC_RATIO: s_n.rdat = s_r.ratio[NCH];
					OFF_MASK: s_n.rdat = 32'(s_r.mask);
					OFF_EVT: begin
						// Read clears; events raised below in this cycle survive
						s_n.rdat = 32'(s_r.evt);
						s_n.evt = '0;
					end
					default: begin
						for (int k = 0; k < NCH; k++) begin
							if (wb_req.adr == 8'(OFF_SCALE + 8'(4 * k))) begin
								s_n.rdat = s_r.cfg[k].scale;
							end
							if (wb_req.adr == 8'(OFF_PICKUP + 8'(4 * k))) begin
								s_n.rdat = s_r.cfg[k].pickup;
							end
							if (wb_req.adr == 8'(OFF_HYST + 8'(4 * k))) begin
								s_n.rdat = s_r.cfg[k].hyst;
							end
							if (wb_req.adr == 8'(OFF_BLKLIM + 8'(4 * k))) begin
								s_n.rdat = s_r.cfg[k].blklim;
							end
							if (wb_req.adr == 8'(OFF_SCALED + 8'(4 * k))) begin
								s_n.rdat = 32'(80'($signed(s_r.scaled[k])) / FX_ONE);
							end
							if (wb_req.adr == 8'(OFF_RATIO + 8'(4 * k))) begin
								s_n.rdat = s_r.ratio[k];
							end
						end
					end
				endcase
			end
		end

		if (s_r.eval) begin
			for (int k = 0; k < NCH; k++) begin
				s_n.ful[k] = ch_en[k] && ful_eval[k];
			end
			s_n.rsel = '0;
			s_n.rgo = 1'b1;
			if (!s_r.en) begin
				s_n.cond = COND_NORMAL;
				s_n.op_cnt = '0;
				s_n.rel_cnt = '0;
				s_n.releasing = 1'b0;
			end else begin
				case (s_r.cond)
					COND_NORMAL: begin
						if (pu && block_in) begin
							s_n.cond = COND_BLOCKED;
							s_n.evt[EVT_BLOCK] = 1'b1;
						end else if (pu) begin
							s_n.cond = COND_START;
							s_n.op_cnt = '0;
							s_n.rel_cnt = '0;
							s_n.evt[EVT_START] = 1'b1;
						end
					end
					COND_START, COND_TRIP: begin
						if (pu && block_in) begin
							// A running start is dropped and its release delay still runs
							s_n.cond = COND_BLOCKED;
							s_n.op_cnt = '0;
							s_n.rel_cnt = '0;
							s_n.releasing = 1'b1;
							s_n.evt[EVT_BLOCK] = 1'b1;
						end else if (!pu) begin
							s_n.rel_cnt = s_r.rel_cnt + 32'h1;
							if (s_n.rel_cnt >= s_r.rel_dly) begin
								s_n.cond = COND_NORMAL;
								s_n.op_cnt = '0;
								s_n.rel_cnt = '0;
								s_n.evt[EVT_RELEASE] = 1'b1;
							end
						end else begin
							s_n.rel_cnt = '0;
							if (s_r.cond == COND_START) begin
								s_n.op_cnt = s_r.op_cnt + 32'h1;
								if (s_n.op_cnt >= s_r.op_dly) begin
									s_n.cond = COND_TRIP;
									s_n.evt[EVT_TRIP] = 1'b1;
								end
							end
						end
					end
					COND_BLOCKED: begin
						if (s_r.releasing) begin
							s_n.rel_cnt = s_r.rel_cnt + 32'h1;
							if (s_n.rel_cnt >= s_r.rel_dly) begin
								s_n.releasing = 1'b0;
								s_n.rel_cnt = '0;
							end
						end
						if ((!pu || !block_in) && !s_n.releasing) begin
							s_n.cond = COND_NORMAL;
							s_n.evt[EVT_RELEASE] = 1'b1;
						end
					end
					default: s_n.cond = COND_NORMAL;
				endcase
			end
		end

		if (div_done) begin
			for (int k = 0; k <= NCH; k++) begin
				if (s_r.rsel == 2'(k)) begin
					s_n.ratio[k] = 32'(sat(80'(div_quo), RATIO_LIM));
				end
			end
			if (s_r.rsel != 2'(NCH)) begin
				s_n.rsel = s_r.rsel + 2'h1;
				s_n.rgo = 1'b1;
			end
		end

		s_n.flags.trip = (s_n.cond == COND_TRIP);
		s_n.flags.blocked = (s_n.cond == COND_BLOCKED);
		s_n.flags.start = (s_n.cond == COND_START) || (s_n.cond == COND_TRIP)
			|| (s_n.cond == COND_BLOCKED && s_n.releasing);
		s_n.irq = |(s_n.evt & s_n.mask);
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
			s_r.en <= CTRL_RST[CTRL_EN_BIT];
			s_r.cnt <= CTRL_RST[CTRL_CNT_LSB +: 2];
			for (int k = 0; k < NCH; k++) begin
				s_r.cfg[k].mode <= MODE_OVER;
				s_r.cfg[k].scale <= SCALE_RST;
				s_r.cfg[k].pickup <= PICKUP_RST;
				s_r.cfg[k].hyst <= HYST_RST;
				s_r.cfg[k].blklim <= BLKLIM_RST;
			end
			s_r.calc_pk <= PICKUP_RST;
			s_r.op_dly <= OP_DLY_RST;
			s_r.rel_dly <= REL_DLY_RST;
			s_r.cond <= COND_NORMAL;
		end else begin
			s_r <= s_n;
		end
	end

	assign wb_ack = s_r.ack;
	assign wb_dat_r = s_r.rdat;
	assign irq = s_r.irq;
	assign flags = s_r.flags;
endmodule

// ### tb/pts_properties.sv
`timescale 1ns/10ps
module pts_properties (
	input wire logic                 ref_clk,  // Clock
	input wire logic                 rst,      // Reset, high
	input wire pts_pkg::pts_wb_req_s wb_req,   // Bus request
	input wire logic                 wb_ack,   // Bus acknowledge
	input wire logic [31:0]          wb_dat_r, // Read data
	input wire logic                 block_in, // Blocking input
	input wire pts_pkg::pts_flags_s  flags     // Stage outputs
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	req_gets_ack_a: assert property (wb_req.cyc && wb_req.stb && !wb_ack |=> wb_ack)
		else $error("request not acknowledged");
	ack_one_cycle_a: assert property (wb_ack |=> !wb_ack)
		else $error("acknowledge longer than one cycle");
	ack_has_cause_a: assert property ($rose(wb_ack) |-> $past(wb_req.cyc && wb_req.stb))
		else $error("acknowledge without request");
	write_reads_zero_a: assert property (wb_ack && wb_req.we |-> wb_dat_r == 32'h0)
		else $error("read data not zero on write");
	trip_holds_start_a: assert property (flags.trip |-> flags.start)
		else $error("trip without start");
	one_condition_a: assert property (!(flags.trip && flags.blocked))
		else $error("trip and blocked together");
	trip_after_start_a: assert property ($rose(flags.trip) |-> $past(flags.start))
		else $error("trip without prior start");
	start_before_trip_a: assert property ($rose(flags.start) |-> !flags.trip)
		else $error("start and trip rose together");
	block_has_cause_a: assert property ($rose(flags.blocked) |->
		$past(block_in, 1) || $past(block_in, 2) || $past(block_in, 3))
		else $error("blocked without blocking input");
endmodule

// ### tb/pts_meas_model.sv
`timescale 1ns/10ps
module pts_meas_model (
	input wire logic              ref_clk,  // Clock
	input wire logic              rst,      // Reset, high
	input wire pts_pkg::pts_meas_t val,      // Wanted samples
	input wire logic              blk,      // Wanted blocking level
	output pts_pkg::pts_meas_t    meas,     // Samples to stage
	output logic                  block_in  // Blocking to stage
);
	import pts_pkg::*;
	// Registered like a real front end, so a change never lands mid-tick edge
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			meas     <= '0;
			block_in <= 1'b0;
		end else begin
			meas     <= val;
			block_in <= blk;
		end
	end
endmodule

// ### tb/pts_stage_bench.sv
`timescale 1ns/10ps
module pts_stage_bench;
	import pts_pkg::*;
	localparam int TC = 256;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	pts_wb_req_s wb_req = '0;
	logic        wb_ack, irq, block_in;
	logic        blk = 1'b0;
	logic [31:0] wb_dat_r, q;
	pts_meas_t   meas;
	pts_meas_t   mv = '0;
	pts_flags_s  flags;
	int          error_cnt = 0;
	int          n_compared = 0;
	int          cyc_cnt = 0;

	always #50 ref_clk = ~ref_clk;

	pts_stage #(.TICK_CYCLES(TC)) u_pts_stage (.ref_clk(ref_clk), .rst(rst), .wb_req(wb_req),
		.wb_ack(wb_ack), .wb_dat_r(wb_dat_r), .irq(irq), .meas(meas), .block_in(block_in),
		.flags(flags));
	pts_meas_model u_pts_meas_model (.ref_clk(ref_clk), .rst(rst), .val(mv), .blk(blk),
		.meas(meas), .block_in(block_in));

	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cyc_cnt++;
		if (cyc_cnt == 40000) begin
			error_cnt++;
			summarize();
		end
	end

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		wb_req <= '{1'b1, 1'b1, we, a, 4'hF, d};
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 50);
		q = wb_dat_r;
		wb_req <= '0;
		if (n >= 50)
			chk("ack", 32'h0, 32'h1);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), q, e);
	endtask

	// Extra tick absorbs the ratio computation that trails each evaluation
	task automatic tk(input int n);
		repeat ((n + 1) * TC) @(posedge ref_clk);
	endtask

	task automatic t_defaults();
		rd(OFF_CTRL, 32'h2);
		rd(OFF_SCALE, 32'h2710);
		rd(OFF_PICKUP, 32'h64);
		rd(OFF_HYST, 32'h7530);
		rd(OFF_OP_DLY, 32'h8);
		rd(OFF_REL_DLY, 32'hC);
		rd(OFF_MODE, 32'h0);
		wr(OFF_COND, 32'h3);
		rd(OFF_COND, 32'h0);
		wr(8'hFC, 32'h5A5A5A5A);
		rd(8'hFC, 32'h0);
		for (int m = 0; m < 8; m++) begin
			wr(OFF_MODE, 32'(m) * 32'h111);
			rd(OFF_MODE, 32'(m) * 32'h111);
		end
		wr(OFF_MODE, 32'h0);
	endtask

	task automatic t_scale();
		wr(OFF_CTRL, 32'h3);
		mv[0] <= 32'd1234;
		tk(1);
		rd(OFF_SCALED, 32'd1234);
		rd(OFF_COND, 32'h1);
		wr(OFF_SCALE, 32'h4E20);
		tk(1);
		rd(OFF_SCALED, 32'd2468);
		mv[0] <= 32'hFFD23940;
		tk(1);
		rd(OFF_SCALED, 32'hFFB3B4C0);
		rd(OFF_RATIO, 32'hE2329B00);
		wr(OFF_SCALE, 32'h2710);
		wr(OFF_PICKUP, 32'h2710);
		wr(OFF_CALC_PK, 32'h2710);
		mv[0] <= 32'd200;
		tk(1);
		rd(OFF_RATIO, 32'h4E20);
		rd(OFF_CALC_RATIO, 32'h4E20);
		// The start left by this scenario must be released before the timing test
		mv[0] <= 32'd0;
		wr(OFF_REL_DLY, 32'h1);
		tk(2);
		rd(OFF_COND, 32'h0);
	endtask

	task automatic t_trip();
		int n;
		wr(OFF_OP_DLY, 32'h2);
		wr(OFF_REL_DLY, 32'h1);
		wr(OFF_MASK, 32'h3);
		wb(1'b0, OFF_EVT, 32'h0);
		mv[0] <= 32'd2;
		n = 0;
		while (flags.start !== 1'b1 && n < 2000) begin
			@(posedge ref_clk);
			n++;
		end
		rd(OFF_EXP_T, 32'd10);
		wb(1'b0, OFF_REM_T, 32'h0);
		chk("remaining", 32'(q == 32'd10 || q == 32'd5), 32'h1);
		repeat (TC - 30) @(posedge ref_clk);
		rd(OFF_COND, 32'h1);
		repeat (TC + 40) @(posedge ref_clk);
		rd(OFF_COND, 32'h2);
		chk("flags", 32'(flags), 32'h6);
		chk("irq", 32'(irq), 32'h1);
		rd(OFF_EVT, 32'h3);
		repeat (3) @(posedge ref_clk);
		chk("irq", 32'(irq), 32'h0);
		mv[0] <= 32'd0;
		tk(2);
		rd(OFF_COND, 32'h0);
		chk("flags", 32'(flags), 32'h0);
	endtask

	task automatic t_hyst();
		wr(OFF_SCALE, 32'h64);
		wr(OFF_OP_DLY, 32'h64);
		mv[0] <= 32'd101;
		tk(1);
		rd(OFF_COND, 32'h1);
		mv[0] <= 32'd98;
		tk(2);
		rd(OFF_COND, 32'h1);
		mv[0] <= 32'd96;
		tk(2);
		rd(OFF_COND, 32'h0);
		wr(OFF_SCALE, 32'h2710);
	endtask

	// A zero sample is under the pick-up, so only the blocking limit keeps it quiet
	task automatic t_under();
		mv[0] <= 32'd0;
		wr(OFF_BLKLIM, 32'd5);
		wr(OFF_MODE, 32'h2);
		tk(2);
		rd(OFF_COND, 32'h0);
		wr(OFF_BLKLIM, 32'd0);
		tk(2);
		rd(OFF_COND, 32'h1);
		wr(OFF_MODE, 32'h0);
		tk(2);
	endtask

	task automatic t_block();
		blk <= 1'b1;
		mv[0] <= 32'd2;
		tk(2);
		rd(OFF_COND, 32'h3);
		chk("flags", 32'(flags), 32'h1);
		blk <= 1'b0;
		mv[0] <= 32'd0;
		tk(2);
		rd(OFF_COND, 32'h0);
	endtask

	task automatic t_multi();
		wr(OFF_CTRL, 32'h5);
		mv[0] <= 32'd2;
		tk(2);
		rd(OFF_COND, 32'h0);
		mv[1] <= 32'd1;
		tk(2);
		rd(OFF_COND, 32'h1);
		mv <= '0;
		tk(2);
	endtask

	// Signed change mode: a rise past the pick-up starts, a fall does not
	task automatic t_delta();
		wr(OFF_CTRL, 32'h3);
		wr(OFF_MODE, 32'h6);
		tk(3);
		rd(OFF_COND, 32'h0);
		mv[0] <= 32'd5;
		tk(1);
		rd(OFF_COND, 32'h1);
		tk(4);
		rd(OFF_COND, 32'h0);
		mv[0] <= 32'd0;
		tk(1);
		rd(OFF_COND, 32'h0);
		wr(OFF_MODE, 32'h0);
	endtask

	initial begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		t_defaults();
		t_scale();
		t_trip();
		t_hyst();
		t_under();
		t_block();
		t_multi();
		t_delta();
		summarize();
	end
endmodule

bind pts_stage pts_properties u_pts_properties (.ref_clk(ref_clk), .rst(rst), .wb_req(wb_req),
	.wb_ack(wb_ack), .wb_dat_r(wb_dat_r), .block_in(block_in), .flags(flags));
